// ===== hdl/dsc_ctrl.sv
// controller that drives a 64k x 1 multiplexed-address dram
module dsc_ctrl #(
  parameter int REF_INTERVAL = dsc_pkg::T_REF_INT,
  parameter int PWRUP_WAIT   = dsc_pkg::T_PWRUP
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_req_valid,
  input  wire dsc_pkg::dsc_req_s i_req,
  output logic                  o_req_ready,
  output logic                  o_rd_valid,
  output logic                  o_rd_data,
  output dsc_pkg::dsc_pins_s    o_pins,
  input  wire logic             i_dout
);
  dsc_pkg::dsc_state_e state;
  logic [dsc_pkg::CNT_W-1:0] cnt;
  logic [dsc_pkg::CNT_W-1:0] ref_cnt;
  logic [6:0]  ref_row;
  logic [3:0]  init_cnt;
  logic        ref_due;
  logic        page_open;
  logic [7:0]  open_row;
  dsc_pkg::dsc_req_s cur;
  logic        dout_m;
  logic        dout_s;

  wire cnt_done  = (cnt == '0);
  // no request is taken until the start-up row cycles are all done
  wire init_done = (init_cnt == 4'(dsc_pkg::INIT_CYCLES));
  wire take      = (state == dsc_pkg::DSC_IDLE) && i_req_valid && !ref_due
                   && init_done; // R23
  wire page_hit  = page_open && (i_req.addr[15:8] == open_row);
  wire page_take = (state == dsc_pkg::DSC_CPRE) && cnt_done && !ref_due
                   && i_req_valid && page_hit;

  assign o_req_ready = take || page_take;

  function automatic logic [dsc_pkg::CNT_W-1:0] ld(input int n);
    return dsc_pkg::CNT_W'(n - 1);
  endfunction

  // dout pin is asynchronous to this clock
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dout_m <= 1'b0;
      dout_s <= 1'b0;
    end else begin
      dout_m <= i_dout;
      dout_s <= dout_m;
    end
  end

  // refresh pacing: interval counts from the end of each refresh, so all 128 rows take at least 2.03ms by default, against the 2ms required
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ref_cnt <= '0;
      ref_due <= 1'b0;
    end else if (state == dsc_pkg::DSC_REF) begin
      ref_due <= 1'b0; // R16
      ref_cnt <= ld(REF_INTERVAL);
    end else if (ref_cnt == '0) begin
      ref_due <= 1'b1; // R16
      ref_cnt <= ld(REF_INTERVAL);
    end else begin
      ref_cnt <= ref_cnt - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state      <= dsc_pkg::DSC_INIT;
      cnt        <= dsc_pkg::CNT_W'(PWRUP_WAIT - 1);
      init_cnt   <= 4'h0;
      ref_row    <= 7'h00;
      page_open  <= 1'b0;
      open_row   <= 8'h00;
      cur        <= '0;
      o_pins     <= '{ras_n: 1'b1, cas_n: 1'b1, write_n: 1'b1,
                      addr: 8'h00, din: 1'b0};
      o_rd_valid <= 1'b0;
      o_rd_data  <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      if (!cnt_done) cnt <= cnt - 1'b1;
      unique case (state)
        // R23: pause, then eight row-strobe cycles as refreshes
        dsc_pkg::DSC_INIT: if (cnt_done) begin
          state <= dsc_pkg::DSC_IDLE;
        end
        dsc_pkg::DSC_IDLE: if (ref_due ||
                               init_cnt != 4'(dsc_pkg::INIT_CYCLES)) begin
          o_pins.addr  <= {1'b0, ref_row}; // R17
          o_pins.ras_n <= 1'b0;
          state        <= dsc_pkg::DSC_REF;
          cnt          <= ld(dsc_pkg::T_RAS);
        end else if (take) begin
          cur          <= i_req;
          o_pins.addr  <= i_req.addr[15:8]; // R1
          o_pins.ras_n <= 1'b0; // R2
          open_row     <= i_req.addr[15:8];
          state        <= dsc_pkg::DSC_ROW;
          cnt          <= ld(dsc_pkg::ROW_ADDR_HOLD_TIME);
        end
        // cas stays high for the whole refresh cycle, no hidden refresh
        dsc_pkg::DSC_REF: if (cnt_done) begin // R22
          o_pins.ras_n <= 1'b1; // R21
          ref_row      <= ref_row + 7'h01; // R25
          if (init_cnt != 4'(dsc_pkg::INIT_CYCLES))
            init_cnt <= init_cnt + 4'h1;
          state        <= dsc_pkg::DSC_PRE;
          cnt          <= ld(dsc_pkg::T_RP);
        end
        dsc_pkg::DSC_ROW: if (cnt_done) begin
          o_pins.addr <= cur.addr[7:0]; // R1
          state       <= dsc_pkg::DSC_COL;
          cnt         <= ld(dsc_pkg::ROW_TO_COLUMN_DELAY - dsc_pkg::ROW_ADDR_HOLD_TIME);
        end
        dsc_pkg::DSC_COL: if (cnt_done) begin
          // early write: write strobe and data set on the same edge that cas falls
          o_pins.write_n <= !cur.write; // R7 R8 R9
          o_pins.din     <= cur.wdata;
          o_pins.cas_n   <= 1'b0; // R3 R4
          state          <= dsc_pkg::DSC_WAIT;
          cnt            <= page_open ? ld(dsc_pkg::T_CAS)
                                      : ld(dsc_pkg::T_RD_ROW); // R14
        end
        // first access is row-limited, later page accesses column-limited
        dsc_pkg::DSC_WAIT: if (cnt_done) begin
          if (!cur.write) begin
            o_rd_data  <= dout_s; // R10 R14
            o_rd_valid <= 1'b1;
          end
          state <= dsc_pkg::DSC_WR;
          cnt   <= ld(dsc_pkg::T_DH);
        end
        dsc_pkg::DSC_WR: if (cnt_done) begin
          o_pins.cas_n   <= 1'b1; // R11
          o_pins.write_n <= 1'b1;
          page_open      <= cur.keep_page; // R13
          state          <= cur.keep_page ? dsc_pkg::DSC_CPRE
                                          : dsc_pkg::DSC_RASX;
          cnt            <= ld(dsc_pkg::T_CP);
        end
        // open page: any column of the held row, reads and writes mixed
        dsc_pkg::DSC_CPRE: if (cnt_done) begin
          if (page_take) begin
            cur         <= i_req;
            o_pins.addr <= i_req.addr[7:0]; // R15
            state       <= dsc_pkg::DSC_COL;
            cnt         <= ld(1);
          end else begin
            state <= dsc_pkg::DSC_RASX;
          end
        end
        dsc_pkg::DSC_RASX: begin
          o_pins.ras_n <= 1'b1;
          page_open    <= 1'b0;
          state        <= dsc_pkg::DSC_PRE;
          cnt          <= ld(dsc_pkg::T_RP); // R25
        end
        dsc_pkg::DSC_PRE: if (cnt_done) begin
          state <= dsc_pkg::DSC_IDLE;
        end
        default: state <= dsc_pkg::DSC_IDLE;
      endcase
    end
  end
endmodule // dsc_ctrl

// ===== hdl/dsc_pkg.sv
// constants and types for the strobe-interface dram controller
// Operation
// R1 - sixteen-bit address sent as two byte halves
// R2 - device latches row on row strobe fall
// R3 - device latches column on column strobe fall
// R4 - column strobe may fall after row hold
// R5 - late column strobe still works, access from column
// R6 - write data latched by later write/column fall
// R7 - early write: write low before column fall; code drops write on the same edge as the column strobe
// R8 - late write: write strobe after column fall
// R9 - reads keep write strobe high throughout
// R10 - read data returns unmodified within access time
// R11 - output floats while column strobe high
// R12 - output valid until column strobe rises
// R13 - page mode: row held, columns strobed
// R14 - first page access later time, then column
// R15 - page spans 256 columns, any order mix
// R16 - all 128 rows refreshed every 2ms; code takes at least 2.03ms at the default interval
// R17 - refresh row address on low seven bits
// R18 - refresh with column high keeps output floating
// R19 - refresh with column low keeps output
// R20 - column rise during refresh floats output
// R21 - never drop column strobe during refresh
// R22 - hidden refresh keeps read data valid
// R23 - wait 500us then eight row cycles
// R24 - early write keeps output open-circuit
// R25 - precharge between cycles, keep row counter
package dsc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int ROW_ADDR_HOLD_NS = 30;
  localparam int ROW_TO_COLUMN_DELAY_NS = 45;
  localparam int ROW_ACCESS_TIME_NS = 250;
  localparam int COLUMN_ACCESS_TIME_NS = 145;
  localparam int RAS_PULSE_NS = 250;
  localparam int RAS_PRECHARGE_NS = 165;
  localparam int CAS_PULSE_NS = 145;
  localparam int CAS_PRECHARGE_NS = 85;
  localparam int WRITE_PULSE_NS = 55;
  localparam int DATA_HOLD_NS = 70;
  localparam int REFRESH_PERIOD_NS = 2000000;
  localparam int POWERUP_NS = 500000;
  localparam int REFRESH_ROWS = 128;
  localparam int INIT_CYCLES = 8;
  function automatic int cyc_min(input int ns);
    return (ns * CLK_MHZ + 999) / 1000 < 1 ? 1 : (ns * CLK_MHZ + 999) / 1000;
  endfunction
  localparam int ROW_ADDR_HOLD_TIME = cyc_min(ROW_ADDR_HOLD_NS);
  localparam int ROW_TO_COLUMN_DELAY = cyc_min(ROW_TO_COLUMN_DELAY_NS);
  localparam int ROW_ACCESS_TIME = cyc_min(ROW_ACCESS_TIME_NS);
  localparam int COLUMN_ACCESS_TIME = cyc_min(COLUMN_ACCESS_TIME_NS) + 2;
  localparam int T_RAS = cyc_min(RAS_PULSE_NS);
  localparam int T_RP = cyc_min(RAS_PRECHARGE_NS);
  localparam int T_CAS = cyc_min(CAS_PULSE_NS) + 2;
  localparam int T_CP = cyc_min(CAS_PRECHARGE_NS);
  localparam int T_WP = cyc_min(WRITE_PULSE_NS);
  localparam int T_DH = cyc_min(DATA_HOLD_NS);
  // first access of a row waits out row access plus three cycles: one edge of margin and the two sync flops
  localparam int T_RD_ROW = ROW_ACCESS_TIME - ROW_TO_COLUMN_DELAY + 3;
  // longest time rounds down
  localparam int T_REF_INT = REFRESH_PERIOD_NS * CLK_MHZ / 1000 / REFRESH_ROWS;
  localparam int T_PWRUP = POWERUP_NS * CLK_MHZ / 1000;
  localparam int CNT_W = 20;
  typedef enum logic [3:0] {
    DSC_INIT = 4'h0, DSC_IDLE = 4'h1, DSC_ROW = 4'h2, DSC_COL = 4'h3,
    DSC_WAIT = 4'h4, DSC_WR = 4'h5, DSC_CPRE = 4'h6, DSC_RASX = 4'h7,
    DSC_PRE = 4'h8, DSC_REF = 4'h9
  } dsc_state_e;
  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic        wdata;
    logic        keep_page;
  } dsc_req_s;
  typedef struct packed {
    logic       ras_n;
    logic       cas_n;
    logic       write_n;
    logic [7:0] addr;
    logic       din;
  } dsc_pins_s;
endpackage

// ===== test/dsc_ctrl_assertions.sv
// port-level checks for the dram controller
module dsc_ctrl_assertions #(
  parameter int REF_INTERVAL = 40,
  parameter int PWRUP_WAIT   = 20
) (
  input wire logic               i_sys_clk,
  input wire logic               i_reset_n,
  input wire logic               i_req_valid,
  input wire dsc_pkg::dsc_req_s  i_req,
  input wire logic               o_req_ready,
  input wire logic               o_rd_valid,
  input wire logic               o_rd_data,
  input wire dsc_pkg::dsc_pins_s o_pins,
  input wire logic               i_dout
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T_RD = dsc_pkg::T_CAS;
  localparam int T_RD1 = dsc_pkg::T_RD_ROW;
  localparam int T_RCDX = dsc_pkg::ROW_TO_COLUMN_DELAY;
  logic [19:0] cyc;
  logic [19:0] gap;
  logic [3:0]  nras;
  logic [4:0]  rlow;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
    if (!i_reset_n) begin
      {cyc, gap, nras, rlow} <= '0;
    end else begin
      rlow <= o_pins.ras_n ? 5'h0 : rlow + {4'h0, ~&rlow};
      cyc <= cyc + {19'h0, ~&cyc};
      gap <= o_pins.ras_n ? gap + 20'h1 : 20'h0;
      nras <= nras + {3'h0, $fell(o_pins.ras_n) && !nras[3]};
    end
  sequence row_setup; o_pins.cas_n [*5]; endsequence
  sequence addr_hold; $stable(o_pins.addr) [*2]; endsequence
  row_hold_a: assert property ($fell(o_pins.ras_n) |=> addr_hold)
    else $error("row address moved too soon");
  col_split_a: assert property ($fell(o_pins.ras_n) |-> row_setup)
    else $error("column strobe too close to row strobe");
  cas_in_row_a: assert property ($fell(o_pins.cas_n) |-> !o_pins.ras_n)
    else $error("column strobe fell outside a row");
  wr_steady_a: assert property (!o_pins.cas_n && !$past(o_pins.cas_n)
    |-> $stable(o_pins.write_n) && $stable(o_pins.din))
    else $error("write or data moved under column strobe");
  read_time_a: assert property ($fell(o_pins.cas_n) && o_pins.write_n
    && rlow > T_RCDX |-> ##T_RD o_rd_valid)
    else $error("read result late or early");
  read_first_a: assert property ($fell(o_pins.cas_n) && o_pins.write_n
    && rlow <= T_RCDX |-> ##T_RD1 o_rd_valid)
    else $error("first read result late or early");
  ras_pre_a: assert property ($rose(o_pins.ras_n) |-> o_pins.ras_n [*8])
    else $error("row precharge too short");
  init_done_a: assert property (o_req_ready |-> nras[3] && cyc >= PWRUP_WAIT)
    else $error("request taken before start-up");
  refresh_gap_a: assert property (gap < REF_INTERVAL + 100)
    else $error("refresh overdue");
endmodule // dsc_ctrl_assertions

// ===== test/dsc_dram_model.sv
// behavioural 64k x 1 dram seen through its strobe pins
module dsc_dram_model (
  input  wire logic       i_ras_n,
  input  wire logic       i_cas_n,
  input  wire logic       i_write_n,
  input  wire logic [7:0] i_addr,
  input  wire logic       i_din,
  output logic            o_dout
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       mem [0:65535];
  logic [7:0] row;
  logic [7:0] col;
  logic       q = 1'b0;
  logic       drv = 1'b0;
  time        t_ras = 0;
  // a released pin shows the inverse of the last bit, so early sampling fails
  assign o_dout = drv ? q : ~q;
  always @(negedge i_ras_n) begin
    row = i_addr;
    t_ras = $time;
  end
  always @(posedge i_cas_n) drv = 1'b0;
  always @(negedge i_cas_n) if (!i_ras_n) begin
    col = i_addr;
    #1; // strobes launched on the same clock edge settle first
    if (!i_write_n) mem[{row, col}] = i_din;
    else begin
      #(dsc_pkg::COLUMN_ACCESS_TIME_NS);
      if (t_ras + dsc_pkg::ROW_ACCESS_TIME_NS > $time)
        #(t_ras + dsc_pkg::ROW_ACCESS_TIME_NS - $time);
      q = mem[{row, col}];
      drv = !i_cas_n;
    end
  end
endmodule // dsc_dram_model

// ===== test/tb_dsc_ctrl.sv
// self-checking bench for the dram controller
module tb_dsc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic               i_sys_clk = 1'b0;
  logic               i_reset_n = 1'b0;
  logic               i_req_valid = 1'b0;
  dsc_pkg::dsc_req_s  i_req = '0;
  logic               o_req_ready;
  logic               o_rd_valid;
  logic               o_rd_data;
  dsc_pkg::dsc_pins_s o_pins;
  logic               i_dout;
  int                 fail_count = 0;
  int                 n_checks = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  dsc_ctrl #(.REF_INTERVAL(200), .PWRUP_WAIT(20)) dut (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_pins(o_pins), .i_dout(i_dout));
  dsc_dram_model u_dram (.i_ras_n(o_pins.ras_n), .i_cas_n(o_pins.cas_n),
    .i_write_n(o_pins.write_n), .i_addr(o_pins.addr), .i_din(o_pins.din),
    .o_dout(i_dout));
  task automatic chk(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic req(input logic w, input logic [15:0] a, input logic d,
                     input logic k);
    int n = 0;
    i_req = '{w, a, d, k};
    i_req_valid = 1'b1;
    #1;
    while (o_req_ready !== 1'b1 && n < 3000) begin
      @(negedge i_sys_clk);
      #1;
      n++;
    end
    chk("request taken", 1'b1, o_req_ready);
    @(negedge i_sys_clk);
    i_req_valid = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic exp, input logic k);
    int n = 0;
    req(1'b0, a, 1'b0, k);
    while (o_rd_valid !== 1'b1 && n < 200) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk("read strobe", 1'b1, o_rd_valid);
    chk("read data", exp, o_rd_data);
  endtask
  task automatic t_reset;
    i_reset_n = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    chk("row strobe idle", 1'b1, o_pins.ras_n);
    i_reset_n = 1'b1;
    repeat (20) begin
      @(negedge i_sys_clk);
      chk("ready in start-up", 1'b0, o_req_ready);
    end
  endtask
  task automatic t_single;
    req(1'b1, 16'h0000, 1'b1, 1'b0);
    req(1'b1, 16'hffff, 1'b0, 1'b0);
    req(1'b1, 16'h00ff, 1'b1, 1'b0);
    rd(16'h0000, 1'b1, 1'b0);
    rd(16'hffff, 1'b0, 1'b0);
    rd(16'h00ff, 1'b1, 1'b0);
  endtask
  task automatic t_page;
    req(1'b1, 16'h5aff, 1'b1, 1'b1);
    req(1'b1, 16'h5a00, 1'b0, 1'b1);
    rd(16'h5aff, 1'b1, 1'b1);
    rd(16'h5a00, 1'b0, 1'b1);
    rd(16'h5aff, 1'b1, 1'b0);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    fail_count++;
    wrap_up();
  end
  initial begin
    t_reset();
    t_single();
    t_page();
    t_reset();
    rd(16'hffff, 1'b0, 1'b0);
    wrap_up();
  end
endmodule // tb_dsc_ctrl
bind dsc_ctrl dsc_ctrl_assertions #(
  .REF_INTERVAL(REF_INTERVAL), .PWRUP_WAIT(PWRUP_WAIT)) u_chk (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid),
  .i_req(i_req), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
  .o_rd_data(o_rd_data), .o_pins(o_pins), .i_dout(i_dout));
